// [rtl/dcap_defines.svh]
// constants for the dual channel converter host port
// assumes one interface clock domain; times are given in cycles of the interface clock
//
// Summary of operation
// - the port makes the converter clock from the oscillator-fed interface clock
// - the demonstration build runs the interface clock and all pins but the converter clock at 50MHz
// - every pin is launched and sampled on the single interface clock
// - the generated clock is driven out on its own pin to the converter
// - channel A arrives on the first data line, B on the second, shifted together
// - conversion settings go out serially on the configuration data line
// - each channel sample is 12 bits and twelve bits are captured per channel
// - capture starts two clock cycles after the busy line falls
// - chip select enables the converter when asserted
// - read/write is driven alongside conversion start
// - the busy line is sampled so the logic can follow the conversion
// - samples go to the application over a streaming valid/ready channel
// - read/write and conversion start pulse high once every 16 clocks
// - configuration is fully written before conversion start pulses begin
// - samples are delivered alternately, channel A first
`ifndef DCAP_DEFINES_SVH
`define DCAP_DEFINES_SVH
`define DCAP_CONV_HZ        32000000
`define DCAP_DEMO_HZ        50000000
`define DCAP_SAMPLE_BITS    12
`define DCAP_PERIOD_CYC     16
`define DCAP_CAPT_DELAY     2
`define DCAP_CFG_BITS       16
`define DCAP_CFG_WORD       16'h5555
`define DCAP_FIFO_DEPTH     32
`endif

// [rtl/dcap_fifo.sv]
// synchronous valid/ready fifo with parameter width and depth
// assumes a single clock and asynchronous active high reset
`default_nettype none
module dcap_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              do_wr = in_valid && in_ready;
  wire              do_rd = out_valid && out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_r] <= in_data;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_wr)
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      if (do_rd)
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  chk_no_overflow: assert property (@(posedge clk) disable iff (rst)
    (cnt_r == (AW+1)'(DEPTH)) |=> (cnt_r <= (AW+1)'(DEPTH)))
    else $error("fifo count above depth");
endmodule : dcap_fifo
`default_nettype wire

// [rtl/dcap_host_port.sv]
// host port that runs a dual channel serial converter and streams its samples
// assumes clk is the oscillator-fed interface clock and all pins are synchronous to it
`include "dcap_defines.svh"
`default_nettype none
module dcap_host_port
  import dcap_pkg::*;
#(
  parameter int          SAMPLE_BITS = `DCAP_SAMPLE_BITS,
  parameter int          PERIOD_CYC  = `DCAP_PERIOD_CYC,
  parameter int          CFG_BITS    = `DCAP_CFG_BITS,
  parameter logic [15:0] CFG_WORD    = `DCAP_CFG_WORD,
  parameter int          FIFO_DEPTH  = `DCAP_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // converter pins
  output logic                        conv_clk_out,
  output logic                        cs_n,
  output logic                        rd_wr,
  output logic                        conv_start,
  output logic                        cfg_sdi,
  input  wire logic                   sdo_a,
  input  wire logic                   sdo_b,
  input  wire logic                   busy,
  // sample stream to the application
  output logic                        smp_valid,
  input  wire logic                   smp_ready,
  output logic [SAMPLE_BITS-1:0]      smp_data,
  output logic                        smp_chan_b,
  // status
  output logic                        overrun
);
  localparam int PW = $clog2(PERIOD_CYC);
  localparam int BW = $clog2(SAMPLE_BITS + 1);
  localparam int CW = $clog2(CFG_BITS + 1);

  dcap_state_t               st_r;
  dcap_state_t               st_nxt;
  logic [PW-1:0]             per_r;
  logic [CW-1:0]             cfg_cnt_r;
  logic [15:0]               cfg_sh_r;
  logic                      busy_q_r;
  logic [1:0]                dly_r;
  logic                      cap_r;
  logic [BW-1:0]             bit_r;
  logic [SAMPLE_BITS-1:0]    sh_a_r;
  logic [SAMPLE_BITS-1:0]    sh_b_r;
  logic                      pend_b_r;
  logic [SAMPLE_BITS-1:0]    hold_b_r;
  logic                      push_r;
  logic [SAMPLE_BITS:0]      push_data_r;
  logic                      clk_div_r;
  logic                      f_valid;
  logic                      f_ready;
  logic [SAMPLE_BITS:0]      f_data;
  logic                      in_ready;
  logic [4:0]                gap_r;
  logic                      seen_r;
  logic [BW-1:0]             cap_len_r;

  // the converter clock is the interface clock divided by two; a toggle flop keeps the pin
  // registered at the cost of running the pin at half the interface rate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      clk_div_r <= 1'b0;
    else
      clk_div_r <= ~clk_div_r;
  end
  assign conv_clk_out = clk_div_r;

  wire busy_fall  = busy_q_r && !busy;
  wire per_end    = (per_r == PW'(PERIOD_CYC-1));
  wire cfg_done   = (cfg_cnt_r == CW'(CFG_BITS));
  wire cap_last   = cap_r && (bit_r == BW'(SAMPLE_BITS-1));
  wire run_active = (st_r == ST_RUN);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: st_nxt = ST_CFG;
      ST_CFG:  st_nxt = cfg_done ? ST_RUN : ST_CFG;
      ST_RUN:  st_nxt = ST_RUN;
      ST_HOLD: st_nxt = ST_RUN;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r      <= ST_IDLE;
      cs_n      <= 1'b1;
      cfg_cnt_r <= '0;
      cfg_sh_r  <= '0;
      cfg_sdi   <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      if (st_r == ST_IDLE)
      begin
        cs_n     <= 1'b0;
        cfg_sh_r <= CFG_WORD;
      end
      else if (st_r == ST_CFG && !cfg_done)
      begin
        cfg_sdi   <= cfg_sh_r[0];
        cfg_sh_r  <= {1'b0, cfg_sh_r[15:1]};
        cfg_cnt_r <= cfg_cnt_r + 1'b1;
      end
      else
        cfg_sdi <= 1'b0;
    end
  end

  // one high cycle per period; rising edge starts the converter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      per_r      <= '0;
      rd_wr      <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      per_r      <= (run_active && !per_end) ? per_r + 1'b1 : '0;
      rd_wr      <= run_active && per_end;
      conv_start <= run_active && per_end;
    end
  end

  // capture begins two cycles after busy falls, both lines shifted together
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_q_r <= 1'b0;
      dly_r    <= '0;
      cap_r    <= 1'b0;
      bit_r    <= '0;
      sh_a_r   <= '0;
      sh_b_r   <= '0;
    end
    else
    begin
      busy_q_r <= busy;
      dly_r    <= {dly_r[0], busy_fall && run_active && !cap_r};
      if (dly_r[1])
      begin
        cap_r <= 1'b1;
        bit_r <= '0;
      end
      else if (cap_last)
        cap_r <= 1'b0;
      if (cap_r || dly_r[1])
      begin
        sh_a_r <= {sh_a_r[SAMPLE_BITS-2:0], sdo_a};
        sh_b_r <= {sh_b_r[SAMPLE_BITS-2:0], sdo_b};
        bit_r  <= dly_r[1] ? BW'(1) : bit_r + 1'b1;
      end
    end
  end

  // capture of the twelfth bit: channel a goes first, b the next cycle
  wire a_done = cap_r && (bit_r == BW'(SAMPLE_BITS-1));
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_b_r    <= 1'b0;
      hold_b_r    <= '0;
      push_r      <= 1'b0;
      push_data_r <= '0;
      overrun     <= 1'b0;
    end
    else
    begin
      push_r <= 1'b0;
      if (a_done)
      begin
        push_r      <= 1'b1;
        push_data_r <= {1'b0, sh_a_r[SAMPLE_BITS-2:0], sdo_a};
        hold_b_r    <= {sh_b_r[SAMPLE_BITS-2:0], sdo_b};
        pend_b_r    <= 1'b1;
      end
      else if (pend_b_r)
      begin
        push_r      <= 1'b1;
        push_data_r <= {1'b1, hold_b_r};
        pend_b_r    <= 1'b0;
      end
      if (push_r && !in_ready)
        overrun <= 1'b1;
    end
  end

  // samples are lost (and overrun flagged) when the fifo is full: the converter
  // cannot be paused mid-conversion, so back-pressure cannot reach it
  dcap_fifo #(
    .WIDTH (SAMPLE_BITS + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_r),
    .in_ready  (in_ready),
    .in_data   (push_data_r),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // registered output stage keeps the stream outputs straight from flops
  assign f_ready = !smp_valid || smp_ready;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      smp_valid  <= 1'b0;
      smp_data   <= '0;
      smp_chan_b <= 1'b0;
    end
    else if (f_ready)
    begin
      smp_valid  <= f_valid;
      smp_data   <= f_data[SAMPLE_BITS-1:0];
      smp_chan_b <= f_data[SAMPLE_BITS];
    end
  end

  // helper counters for the long windows: cycles since the last start pulse and
  // length of the current capture window, kept out of long repetitions
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gap_r     <= '0;
      seen_r    <= 1'b0;
      cap_len_r <= '0;
    end
    else
    begin
      gap_r     <= conv_start ? 5'h00 : gap_r + 5'h01;
      seen_r    <= seen_r || conv_start;
      cap_len_r <= cap_r ? cap_len_r + 1'b1 : '0;
    end
  end

  chk_start_period: assert property (@(posedge clk) disable iff (rst)
    (conv_start && seen_r) |-> (gap_r == 5'h0F))
    else $error("conversion start pulsed too often");
  chk_start_rdwr: assert property (@(posedge clk) disable iff (rst)
    conv_start == rd_wr)
    else $error("read/write not aligned with conversion start");
  chk_cfg_first: assert property (@(posedge clk) disable iff (rst)
    conv_start |-> cfg_done)
    else $error("conversion start before configuration done");
  chk_cs_held: assert property (@(posedge clk) disable iff (rst)
    run_active |-> !cs_n)
    else $error("chip select dropped during run");
  chk_cap_delay: assert property (@(posedge clk) disable iff (rst)
    (busy_fall && run_active && !cap_r) |-> ##2 (cap_r || dly_r[1]))
    else $error("capture not started two cycles after busy fall");
  chk_b_follows_a: assert property (@(posedge clk) disable iff (rst)
    (push_r && !push_data_r[SAMPLE_BITS]) |=> (push_r && push_data_r[SAMPLE_BITS]))
    else $error("channel b sample did not follow channel a");
  chk_twelve_bits: assert property (@(posedge clk) disable iff (rst)
    $fell(cap_r) |-> (cap_len_r == BW'(SAMPLE_BITS-1)))
    else $error("capture window not twelve bits");
  chk_period_pulse: assert property (@(posedge clk) disable iff (rst)
    conv_start && run_active |-> ##16 conv_start)
    else $error("conversion start missing after sixteen cycles");
  chk_stream_hold: assert property (@(posedge clk) disable iff (rst)
    (smp_valid && !smp_ready) |=> (smp_valid && $stable(smp_data)))
    else $error("stream sample changed while stalled");

  cov_first_start: cover property (@(posedge clk) disable iff (rst) $rose(conv_start));
  cov_sample_pair: cover property (@(posedge clk) disable iff (rst) a_done ##1 pend_b_r);
  cov_stall:       cover property (@(posedge clk) disable iff (rst) smp_valid && !smp_ready);
  cov_overrun:     cover property (@(posedge clk) disable iff (rst) $rose(overrun));
endmodule : dcap_host_port
`default_nettype wire

// [rtl/dcap_pkg.sv]
// types for the dual channel converter host port
// assumes dcap_defines.svh is available on the include path
`default_nettype none
package dcap_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CFG  = 4'b0010,
    ST_RUN  = 4'b0100,
    ST_HOLD = 4'b1000
  } dcap_state_t;
endpackage : dcap_pkg
`default_nettype wire

// [test/dcap_adc_model.sv]
// behavioural two channel serial converter facing the host port
// assumes the host samples on rising clk; this model moves on falling clk
`default_nettype none
module dcap_adc_model #(
  parameter int BUSY_CYC = 1
) (
  // shared interface clock, and control from the host
  input  wire logic        clk,
  input  wire logic        cs_n,
  input  wire logic        conv_start,
  // status and results to the host
  output logic             busy,
  output logic             sdo_a,
  output logic             sdo_b,
  // values the bench wants converted
  input  wire logic [11:0] val_a,
  input  wire logic [11:0] val_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] sh_a;
  logic [11:0] sh_b;
  logic        last;
  int          cnt;
  initial
  begin
    busy = 1'b0;
    sdo_a = 1'b0;
    sdo_b = 1'b1;
    last = 1'b0;
    cnt = -1;
  end
  always @(negedge clk)
  begin
    if (conv_start && !last && !cs_n)
    begin
      sh_a = val_a;
      sh_b = val_b;
      busy = 1'b1;
      cnt = 0;
    end
    else if (cnt >= 0)
    begin
      cnt++;
      if (cnt == BUSY_CYC)
        busy = 1'b0;
      if (cnt > BUSY_CYC + 13)
        cnt = -1;
    end
    // outside the data bits the lines never hold a stale value
    if (cnt >= BUSY_CYC + 2 && cnt <= BUSY_CYC + 13)
    begin
      sdo_a = sh_a[11];
      sdo_b = sh_b[11];
      sh_a = sh_a << 1;
      sh_b = sh_b << 1;
    end
    else
    begin
      sdo_a = ~sdo_a;
      sdo_b = ~sdo_b;
    end
    last = conv_start;
  end
endmodule : dcap_adc_model
`default_nettype wire

// [test/tb_dcap_host_port.sv]
// self-checking bench for the converter host port
// assumes the behavioural converter model and default design parameters
`include "dcap_defines.svh"
`default_nettype none
module tb_dcap_host_port;
  import dcap_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, smp_ready, conv_clk_out, cs_n, rd_wr, conv_start, cfg_sdi;
  logic        sdo_a, sdo_b, busy, smp_valid, smp_chan_b, overrun;
  logic [11:0] smp_data, val_a, val_b;
  int          n_errors, comparisons;

  dcap_host_port u_dcap_host_port (.clk(clk), .rst(rst), .conv_clk_out(conv_clk_out),
    .cs_n(cs_n), .rd_wr(rd_wr), .conv_start(conv_start), .cfg_sdi(cfg_sdi), .sdo_a(sdo_a),
    .sdo_b(sdo_b), .busy(busy), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .smp_chan_b(smp_chan_b), .overrun(overrun));
  dcap_adc_model u_dcap_adc_model (.clk(clk), .cs_n(cs_n), .conv_start(conv_start),
    .busy(busy), .sdo_a(sdo_a), .sdo_b(sdo_b), .val_a(val_a), .val_b(val_b));

  always #4 clk = ~clk;

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic get_sample(logic chan_b, logic [11:0] d);
    int i;
    for (i = 0; i < 100 && smp_valid !== 1'b1; i++)
      @(negedge clk);
    check("sample channel", {15'h0, chan_b}, {15'h0, smp_chan_b});
    check("sample data", {4'h0, d}, {4'h0, smp_data});
    @(negedge clk);
  endtask : get_sample

  task automatic settle(logic [11:0] a, logic [11:0] b);
    smp_ready = 1'b1;
    val_a = a;
    val_b = b;
    repeat (40) @(negedge clk);
    // line up just after a pair has drained so the next sample is channel a
    while (conv_start !== 1'b1)
      @(negedge clk);
    repeat (4) @(negedge clk);
  endtask : settle

  task automatic t_reset();
    int i;
    check("cs in reset", 16'h1, {15'h0, cs_n});
    check("start in reset", 16'h0, {15'h0, conv_start});
    rst = 1'b0;
    @(negedge clk);
    check("cs after reset", 16'h0, {15'h0, cs_n});
    for (i = 0; i < 16; i++)
    begin
      @(negedge clk);
      check("config bit", {15'h0, 1'(`DCAP_CFG_WORD >> i)}, {15'h0, cfg_sdi});
      check("start in config", 16'h0, {15'h0, conv_start});
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_period();
    int  gap;
    logic ck;
    for (gap = 0; gap < 60 && conv_start !== 1'b1; gap++)
      @(negedge clk);
    ck = conv_clk_out;
    for (gap = 1; gap < 40; gap++)
    begin
      @(negedge clk);
      check("clock out", {15'h0, ~ck}, {15'h0, conv_clk_out});
      ck = conv_clk_out;
      check("read write", {15'h0, conv_start}, {15'h0, rd_wr});
      check("chip select held", 16'h0, {15'h0, cs_n});
      if (conv_start === 1'b1)
        break;
    end
    check("start spacing", 16'd16, gap[15:0]);
    @(negedge clk);
    check("start width", 16'h0, {15'h0, conv_start});
    $display("test period done");
  endtask : t_period

  task automatic t_stream(logic [11:0] a, logic [11:0] b);
    settle(a, b);
    repeat (4)
    begin
      get_sample(1'b0, a);
      get_sample(1'b1, b);
    end
    check("no overrun", 16'h0, {15'h0, overrun});
    $display("test stream done");
  endtask : t_stream

  task automatic t_stall();
    logic [11:0] d;
    logic        f;
    settle(12'h801, 12'h7FE);
    smp_ready = 1'b0;
    @(negedge clk);
    while (smp_valid !== 1'b1)
      @(negedge clk);
    d = smp_data;
    f = smp_chan_b;
    repeat (600)
    begin
      @(negedge clk);
      check("held valid", 16'h1, {15'h0, smp_valid});
      check("held data", {4'h0, d}, {4'h0, smp_data});
    end
    check("overrun", 16'h1, {15'h0, overrun});
    smp_ready = 1'b1;
    for (int k = 0; k < 32; k++)
      get_sample(f ^ k[0], (f ^ k[0]) ? 12'h7FE : 12'h801);
    $display("test stall done");
  endtask : t_stall

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    smp_ready = 1'b0;
    val_a = 12'hA5C;
    val_b = 12'h3E1;
    n_errors = 0;
    comparisons = 0;
    repeat (2) @(negedge clk);
    t_reset();
    t_period();
    t_stream(12'hA5C, 12'h3E1);
    t_stream(12'hFFF, 12'h000);
    t_stall();
    results();
  end

  initial
  begin
    #(8 * 6000);
    n_errors++;
    results();
  end
endmodule : tb_dcap_host_port
`default_nettype wire
